// ==== usb2_host_port_phy_control.sv ====
/*
  Register block for USB 2.0 host port control upper fields, FIFO
  thresholds, PHY state readback, indirect PHY control loading, loopback
  self-test, clock-gating power saving and calibration arithmetic.
  Assumes an Avalon-MM master on clk and that all port, PHY and FIFO
  side inputs come from logic on the same clock.
*/
`timescale 1ns/10ps
module usb2_host_port_phy_control #(
  parameter int FILL_W = 12
) (
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  // Avalon-MM slave
  input  wire logic [7:0]                             avsAddress,
  input  wire logic                                   avsRead,
  input  wire logic                                   avsWrite,
  input  wire logic [31:0]                            avsWriteData,
  input  wire logic [3:0]                             avsByteEnable,
  output logic [31:0]                                 avsReadData,
  output logic                                        avsWaitRequest,
  // Controller state
  input  wire logic                                   configure_flag_register,
  input  wire logic                                   indicatorCapable,
  input  wire logic                                   controllerRunning,
  input  wire logic                                   connectIrq,
  // Per-port events and controls
  input  wire logic [usb2_phy_ctrl_pkg::NUM_PORTS-1:0]   connectEvent,
  input  wire logic [usb2_phy_ctrl_pkg::NUM_PORTS-1:0]   disconnectEvent,
  input  wire logic [usb2_phy_ctrl_pkg::NUM_PORTS-1:0]   overCurrentEvent,
  output logic [usb2_phy_ctrl_pkg::NUM_PORTS-1:0]        wakeEvent,
  output logic [usb2_phy_ctrl_pkg::NUM_PORTS-1:0]        companionOwned,
  output logic [2*usb2_phy_ctrl_pkg::NUM_PORTS-1:0]      indicatorState,
  output logic [4*usb2_phy_ctrl_pkg::NUM_PORTS-1:0]      phy_test_select,
  input  wire logic [8*usb2_phy_ctrl_pkg::NUM_PORTS-1:0] portPhyState,
  // FIFO thresholds
  input  wire logic [FILL_W-1:0]                      rxFifoBytes,
  input  wire logic [FILL_W-1:0]                      txFifoBytes,
  output logic                                        rxBusStart,
  output logic                                        txUtmiStart,
  // PHY control loader
  output logic                                        phyLoadReq,
  output logic [3:0]                                  phyLoadTarget,
  output logic [6:0]                                  phyLoadValue,
  output logic                                        phyLoadGroup,
  output logic                                        phyLoadFull,
  input  wire logic                                   phyLoadAck,
  // Loopback self-test
  output logic                                        loopbackEnable,
  input  wire logic                                   loopbackDone,
  input  wire logic                                   loopbackCrcGood,
  // Clock gating and calibration
  output logic                                        memClockOff,
  output logic                                        busClockOff,
  output logic [6:0]                                  phyCalValue
);
  localparam int NP = usb2_phy_ctrl_pkg::NUM_PORTS;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                             input logic [31:0] newW,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = oldW;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  function automatic logic targetValid(input logic [3:0] t);
    return (t <= usb2_phy_ctrl_pkg::TARGET_LAST) || (t == usb2_phy_ctrl_pkg::TARGET_COMMON);
  endfunction : targetValid

  // Bus handshake: one wait cycle, answer at the second edge
  logic        ackQ;
  logic [31:0] rdDataQ;
  wire         access = avsRead | avsWrite;
  wire         wrFire = avsWrite & ackQ;
  assign avsWaitRequest = access & ~ackQ;
  assign avsReadData    = rdDataQ;

  // Port registers
  logic [NP-1:0]       ownerQ;
  logic [NP-1:0][1:0]  indQ;
  logic [NP-1:0][3:0]  testQ;
  logic [NP-1:0][2:0]  wakeEnQ;
  logic [NP-1:0]       wakeQ;
  logic [NP-1:0][31:0] portWord;
  logic [NP-1:0][7:0]  phyByte;
  logic                cfgPrevQ;
  wire                 cfgRise = configure_flag_register & ~cfgPrevQ;

  for (genvar i = 0; i < NP; i++) begin : g_port
    wire [7:0]  portOff = 8'(int'(usb2_phy_ctrl_pkg::OFF_PORT_STATUS) + 4 * i);
    wire        portHit = wrFire && (avsAddress == portOff);
    wire [31:0] portWd  = mergeBytes(portWord[i], avsWriteData, avsByteEnable);
    wire [2:0]  evts    = {overCurrentEvent[i], disconnectEvent[i], connectEvent[i]};
    assign portWord[i] = {9'h000, wakeEnQ[i], testQ[i], indQ[i], ownerQ[i], 13'h0000};
    // top bit of each state byte reads zero
    assign phyByte[i]  = {1'b0, portPhyState[8*i +: 7]};
    // owner bit hands the port to the companion
    assign companionOwned[i]        = ownerQ[i];
    assign indicatorState[2*i +: 2] = indQ[i];
    // test mode code straight to the port
    assign phy_test_select[4*i +: 4]       = testQ[i];
    assign wakeEvent[i]             = wakeQ[i];

    always_ff @(posedge clk) begin
      if (!rstn) begin
        ownerQ[i]  <= usb2_phy_ctrl_pkg::OWNER_RESET;
        indQ[i]    <= usb2_phy_ctrl_pkg::IND_OFF;
        testQ[i]   <= usb2_phy_ctrl_pkg::TEST_NONE;
        wakeEnQ[i] <= 3'h0;
        wakeQ[i]   <= 1'b0;
      end else begin
        if (!configure_flag_register) begin
          ownerQ[i] <= 1'b1;
        end else if (cfgRise) begin
          ownerQ[i] <= 1'b0;
        end else if (portHit) begin
          ownerQ[i] <= portWd[usb2_phy_ctrl_pkg::OWNER_BIT];
        end
        if (portHit && indicatorCapable) begin
          indQ[i] <= portWd[usb2_phy_ctrl_pkg::IND_LSB +: 2];
        end
        if (portHit) begin
          testQ[i]   <= portWd[usb2_phy_ctrl_pkg::TEST_LSB +: 4];
          wakeEnQ[i] <= portWd[usb2_phy_ctrl_pkg::WAKE_LSB +: 3];
        end
        wakeQ[i] <= |(wakeEnQ[i] & evts);
      end
    end
  end

  // Thresholds
  logic [7:0] inThrQ;
  logic [7:0] outThrQ;
  wire [31:0] thrWord = {8'h00, outThrQ, 8'h00, inThrQ};
  wire [31:0] thrWd   = mergeBytes(thrWord, avsWriteData, avsByteEnable);
  wire        thrHit  = wrFire && (avsAddress == usb2_phy_ctrl_pkg::OFF_THRESHOLDS);

  fifo_threshold_gate #(.FILL_W(FILL_W)) u_rx_gate (
    .clk            (clk),
    .rstn           (rstn),
    .thresholdUnits (inThrQ),
    .fillBytes      (rxFifoBytes),
    .startOk        (rxBusStart)
  );
  fifo_threshold_gate #(.FILL_W(FILL_W)) u_tx_gate (
    .clk            (clk),
    .rstn           (rstn),
    .thresholdUnits (outThrQ),
    .fillBytes      (txFifoBytes),
    .startOk        (txUtmiStart)
  );

  // PHY control loader
  logic [6:0] vctrlQ;
  logic       groupQ;
  logic       loadNQ;
  logic [3:0] targetQ;
  logic       busyQ;
  logic [3:0] reqTargetQ;
  logic [6:0] reqValueQ;
  logic       reqGroupQ;
  logic       reqFullQ;
  wire [31:0] ldWord = {14'h0000, busyQ, targetQ, loadNQ, 4'h0, groupQ, vctrlQ};
  wire [31:0] ldMerge = mergeBytes(ldWord, avsWriteData, avsByteEnable);
  wire [31:0] ldWd = busyQ ?
                     {ldMerge[31:17], ldWord[16:8], ldMerge[7:0]} : ldMerge;
  wire        ldHit = wrFire && (avsAddress == usb2_phy_ctrl_pkg::OFF_PHY_LOADER);
  wire [3:0]  ldTarget = ldWd[usb2_phy_ctrl_pkg::TARGET_LSB +: 4];
  wire        ldStart = ldHit && !busyQ && (avsByteEnable[1] || avsByteEnable[2])
                        && targetValid(ldTarget);
  // group zero passes all seven bits; group one keeps test select
  wire [6:0]  ldValue = ldWd[usb2_phy_ctrl_pkg::GROUP_BIT] ? {3'h0, ldWd[3:0]} : ldWd[6:0];

  assign phyLoadReq    = busyQ;
  assign phyLoadTarget = reqTargetQ;
  assign phyLoadValue  = reqValueQ;
  assign phyLoadGroup  = reqGroupQ;
  assign phyLoadFull   = reqFullQ;

  // Loopback, power, calibration
  logic       lbEnQ;
  logic       lbGoodQ;
  logic       lbDoneQ;
  logic       pwrSaveQ;
  logic       memOffQ;
  logic       busOffQ;
  logic [6:0] calBaseQ;
  logic [7:0] calOfsQ;
  logic       calRawQ;
  logic       calAddQ;
  logic [6:0] calOut;
  logic [6:0] calQ;
  wire [31:0] lbWord  = {21'h000000, lbDoneQ, lbGoodQ, lbEnQ, 8'h00};
  wire [31:0] lbWd    = mergeBytes(lbWord, avsWriteData, avsByteEnable);
  wire        lbHit   = wrFire && (avsAddress == usb2_phy_ctrl_pkg::OFF_LOOPBACK);
  // A fresh enable starts a new test, so the old done flag is dropped then
  wire        lbStart = lbHit && lbWd[usb2_phy_ctrl_pkg::LB_EN_BIT] && !lbEnQ;
  wire [31:0] miscWord = {19'h00000, pwrSaveQ, 12'h000};
  wire [31:0] miscWd   = mergeBytes(miscWord, avsWriteData, avsByteEnable);
  wire        miscHit  = wrFire && (avsAddress == usb2_phy_ctrl_pkg::OFF_MISC);
  wire [31:0] calWord  = {14'h0000, calAddQ, calRawQ, calOfsQ, 1'b0, calBaseQ};
  wire [31:0] calWd    = mergeBytes(calWord, avsWriteData, avsByteEnable);
  wire        calHit   = wrFire && (avsAddress == usb2_phy_ctrl_pkg::OFF_CAL);

  assign loopbackEnable = lbEnQ;
  assign memClockOff    = memOffQ;
  assign busClockOff    = busOffQ;
  assign phyCalValue    = calQ;

  calibration_adjust u_cal (
    .baseValue   (calBaseQ),
    .offsetValue (calOfsQ),
    .passRaw     (calRawQ),
    .addOffset   (calAddQ),
    .calValue    (calOut)
  );

  // Read decode
  wire [7:0]  portDelta = avsAddress - usb2_phy_ctrl_pkg::OFF_PORT_STATUS;
  wire [5:0]  portIdx   = portDelta[7:2];
  wire        inPort    = (avsAddress >= usb2_phy_ctrl_pkg::OFF_PORT_STATUS)
                          && (portIdx < 6'(NP)) && (portDelta[1:0] == 2'h0);
  wire [31:0] portRd    = inPort ? portWord[portIdx[3:0]] : 32'h00000000;
  // state bytes packed four to a word, the last word holding two in its upper half
  wire [31:0] phyRd0 = {phyByte[3], phyByte[2], phyByte[1], phyByte[0]};
  wire [31:0] phyRd1 = {phyByte[7], phyByte[6], phyByte[5], phyByte[4]};
  wire [31:0] phyRd2 = {phyByte[9], phyByte[8], 16'h0000};
  wire [31:0] rdMux =
    inPort ? portRd :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_THRESHOLDS) ? thrWord :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_PHY_STATE0) ? phyRd0 :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_PHY_STATE1) ? phyRd1 :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_PHY_STATE2) ? phyRd2 :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_PHY_LOADER) ? ldWord :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_LOOPBACK)   ? lbWord :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_MISC)       ? miscWord :
    (avsAddress == usb2_phy_ctrl_pkg::OFF_CAL)        ? calWord : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ackQ     <= 1'b0;
      rdDataQ  <= 32'h00000000;
      cfgPrevQ <= 1'b0;
    end else begin
      ackQ     <= access & ~ackQ;
      cfgPrevQ <= configure_flag_register;
      if (avsRead && !ackQ) begin
        rdDataQ <= rdMux;
      end
    end
  end

  // out-of-range thresholds are stored as written
  always_ff @(posedge clk) begin
    if (!rstn) begin
      inThrQ  <= usb2_phy_ctrl_pkg::IN_THR_RESET;
      outThrQ <= usb2_phy_ctrl_pkg::OUT_THR_RESET;
    end else if (thrHit) begin
      inThrQ  <= thrWd[usb2_phy_ctrl_pkg::IN_THR_LSB +: 8];
      outThrQ <= thrWd[usb2_phy_ctrl_pkg::OUT_THR_LSB +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      vctrlQ  <= 7'h00;
      groupQ  <= 1'b0;
      loadNQ  <= usb2_phy_ctrl_pkg::LOAD_N_RESET;
      targetQ <= 4'h0;
    end else if (ldHit) begin
      vctrlQ  <= ldWd[6:0];
      groupQ  <= ldWd[usb2_phy_ctrl_pkg::GROUP_BIT];
      loadNQ  <= ldWd[usb2_phy_ctrl_pkg::LOAD_N_BIT];
      targetQ <= ldTarget;
    end
  end

  // busy held until the router acknowledges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busyQ      <= 1'b0;
      reqTargetQ <= 4'h0;
      reqValueQ  <= 7'h00;
      reqGroupQ  <= 1'b0;
      reqFullQ   <= 1'b0;
    end else if (ldStart) begin
      busyQ      <= 1'b1;
      reqTargetQ <= ldTarget;
      reqValueQ  <= ldValue;
      reqGroupQ  <= ldWd[usb2_phy_ctrl_pkg::GROUP_BIT];
      // active-low load bit selects full load
      reqFullQ   <= !ldWd[usb2_phy_ctrl_pkg::LOAD_N_BIT];
    end else if (phyLoadAck) begin
      busyQ      <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lbEnQ   <= 1'b0;
      lbGoodQ <= 1'b0;
      lbDoneQ <= 1'b0;
    end else begin
      // enable drives the external loopback test
      if (lbHit) begin
        lbEnQ <= lbWd[usb2_phy_ctrl_pkg::LB_EN_BIT];
      end
      // completion wins over a restart clear
      if (loopbackDone) begin
        lbDoneQ <= 1'b1;
        lbGoodQ <= loopbackCrcGood;
      end else if (lbStart) begin
        lbDoneQ <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwrSaveQ <= 1'b0;
      memOffQ  <= 1'b0;
      busOffQ  <= 1'b0;
    end else begin
      if (miscHit) begin
        pwrSaveQ <= miscWd[usb2_phy_ctrl_pkg::PWR_SAVE_BIT];
      end
      // gate when saving and not running; the bus clock also stays on while connectIrq is high
      memOffQ <= pwrSaveQ && !controllerRunning;
      busOffQ <= pwrSaveQ && !controllerRunning && !connectIrq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      calBaseQ <= usb2_phy_ctrl_pkg::CAL_BASE_RESET;
      calOfsQ  <= 8'h00;
      calRawQ  <= 1'b0;
      calAddQ  <= 1'b0;
      calQ     <= usb2_phy_ctrl_pkg::CAL_BASE_RESET;
    end else begin
      if (calHit) begin
        calBaseQ <= calWd[6:0];
        calOfsQ  <= calWd[usb2_phy_ctrl_pkg::CAL_OFS_LSB +: 8];
        calRawQ  <= calWd[usb2_phy_ctrl_pkg::CAL_RAW_BIT];
        calAddQ  <= calWd[usb2_phy_ctrl_pkg::CAL_ADD_BIT];
      end
      calQ <= calOut;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_owner_forced: assert property (!configure_flag_register |=> &ownerQ)
    else $error("owner not forced while unconfigured");
  chk_owner_rise: assert property (cfgRise |=> ownerQ == '0)
    else $error("owner not cleared on configure rise");
  chk_ind_blocked: assert property (
    !indicatorCapable |=> $stable(indicatorState))
    else $error("indicator changed without capability");
  chk_wake_connect: assert property (
    connectEvent[0] && wakeEnQ[0][0] |=> wakeEvent[0])
    else $error("enabled connect gave no wake");
  chk_rx_gate: assert property (
    ({4'h0, rxFifoBytes} >= {inThrQ, 3'h0}) && $stable(rxFifoBytes) && $stable(inThrQ)
    |=> rxBusStart)
    else $error("receive start missing at threshold");
  chk_busy_block: assert property (
    busyQ && ldHit |=> $stable(ldWord[16:8]))
    else $error("loader bits changed while busy");
  chk_target_reserved: assert property (
    ldHit && !busyQ && !targetValid(ldTarget) |=> !busyQ)
    else $error("reserved target started a load");
  chk_load_value: assert property (
    ldStart && ldWd[usb2_phy_ctrl_pkg::GROUP_BIT] |=> phyLoadReq && phyLoadValue[6:4] == 3'h0)
    else $error("group one value carries high bits");
  chk_loop_done: assert property (
    loopbackDone |=> lbDoneQ && (lbGoodQ == $past(loopbackCrcGood)))
    else $error("loopback result not captured");
  chk_mem_gate: assert property (
    pwrSaveQ && !controllerRunning |=> memClockOff)
    else $error("memory clock not gated");
  chk_cal_raw: assert property (
    calRawQ && $stable(calBaseQ) |=> phyCalValue == $past(calBaseQ))
    else $error("raw calibration not passed");
  chk_bus_answer: assert property (access |-> ##[0:1] !avsWaitRequest)
    else $error("bus answer late");

  cov_owner_rise: cover property (cfgRise ##1 ownerQ == '0);
  cov_phy_load:   cover property (ldStart ##[1:20] phyLoadAck);
  cov_loop_done:  cover property (lbEnQ ##[1:50] lbDoneQ);
  cov_cal_clamp:  cover property (calAddQ && calOfsQ[7] && calQ == 7'h00);
endmodule : usb2_host_port_phy_control

// ==== usb2_phy_ctrl_pkg.sv ====
/*
  Constants for the USB 2.0 host port and PHY control register block:
  register offsets, field positions, reset values and code points.
  Assumes byte addresses on an Avalon-MM slave with 32-bit data.
*/
package usb2_phy_ctrl_pkg;
  localparam int          NUM_PORTS      = 10;
  // Register byte offsets
  localparam logic [7:0]  OFF_PORT_STATUS = 8'h44;
  localparam logic [7:0]  OFF_THRESHOLDS = 8'h84;
  localparam logic [7:0]  OFF_PHY_STATE0 = 8'h88;
  localparam logic [7:0]  OFF_PHY_STATE1 = 8'h8C;
  localparam logic [7:0]  OFF_PHY_STATE2 = 8'h90;
  localparam logic [7:0]  OFF_PHY_LOADER = 8'h94;
  localparam logic [7:0]  OFF_LOOPBACK   = 8'h98;
  localparam logic [7:0]  OFF_MISC       = 8'h9C;
  localparam logic [7:0]  OFF_CAL        = 8'hA0;
  // Port status and control upper fields
  localparam int          OWNER_BIT      = 13;
  localparam int          IND_LSB        = 14;
  localparam int          TEST_LSB       = 16;
  localparam int          WAKE_LSB       = 20;
  localparam logic        OWNER_RESET    = 1'b1;
  localparam logic [1:0]  IND_OFF        = 2'h0;
  localparam logic [1:0]  IND_AMBER      = 2'h1;
  localparam logic [1:0]  IND_GREEN      = 2'h2;
  localparam logic [3:0]  TEST_NONE      = 4'h0;
  localparam logic [3:0]  TEST_SE0_NAK   = 4'h3;
  localparam logic [3:0]  TEST_PACKET    = 4'h4;
  // Thresholds, in units of eight bytes
  localparam int          IN_THR_LSB     = 0;
  localparam int          OUT_THR_LSB    = 16;
  localparam logic [7:0]  IN_THR_RESET   = 8'h10;
  localparam logic [7:0]  OUT_THR_RESET  = 8'h60;
  localparam int          THR_UNIT_SHIFT = 3;
  // PHY control loader
  localparam int          GROUP_BIT      = 7;
  localparam int          LOAD_N_BIT     = 12;
  localparam int          TARGET_LSB     = 13;
  localparam int          BUSY_BIT       = 17;
  localparam int          BLOCK_LSB      = 8;
  localparam int          BLOCK_MSB      = 16;
  localparam logic        LOAD_N_RESET   = 1'b1;
  localparam logic [3:0]  TARGET_LAST    = 4'h9;
  localparam logic [3:0]  TARGET_COMMON  = 4'hF;
  // Loopback, power and calibration
  localparam int          LB_EN_BIT      = 8;
  localparam int          LB_STATUS_BIT  = 9;
  localparam int          LB_DONE_BIT    = 10;
  localparam int          PWR_SAVE_BIT   = 12;
  localparam int          CAL_OFS_LSB    = 8;
  localparam int          CAL_RAW_BIT    = 16;
  localparam int          CAL_ADD_BIT    = 17;
  localparam logic [6:0]  CAL_BASE_RESET = 7'h00;
  localparam logic [6:0]  CAL_MAX        = 7'h7F;
endpackage : usb2_phy_ctrl_pkg

// ==== fifo_threshold_gate.sv ====
/*
  Compares a FIFO fill level in bytes with a threshold in eight-byte units
  and raises a registered start level while the threshold is reached.
  Assumes the fill count comes from logic on the same clock.
*/
`timescale 1ns/10ps
module fifo_threshold_gate #(
  parameter int FILL_W = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Threshold and fill
  input  wire logic [7:0]        thresholdUnits,
  input  wire logic [FILL_W-1:0] fillBytes,
  // Start level
  output logic                   startOk
);
  wire [FILL_W+2:0] limitBytes = (FILL_W+3)'({thresholdUnits, 3'h0});
  wire              reached    = (FILL_W+3)'(fillBytes) >= limitBytes;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      startOk <= 1'b0;
    end else begin
      startOk <= reached;
    end
  end
endmodule : fifo_threshold_gate

// ==== calibration_adjust.sv ====
/*
  Forms the calibration value sent to the PHY ports from the base value,
  a signed offset and two select bits. Purely combinational.
  Assumes the caller registers the result.
*/
`timescale 1ns/10ps
module calibration_adjust (
  // Operands
  input  wire logic [6:0] baseValue,
  input  wire logic [7:0] offsetValue,
  // Selects
  input  wire logic       passRaw,
  input  wire logic       addOffset,
  // Result
  output logic [6:0]      calValue
);
  wire signed [8:0] offsetSx = {offsetValue[7], offsetValue};
  wire signed [8:0] baseSx   = {2'h0, baseValue};
  wire signed [8:0] sum      = baseSx + offsetSx;
  wire        under   = sum[8];
  wire        over    = !sum[8] && sum[7];
  wire [6:0]  clamped = under ? 7'h00 : (over ? usb2_phy_ctrl_pkg::CAL_MAX : sum[6:0]);
  wire [6:0]  adjusted = addOffset ? clamped : offsetValue[6:0];
  assign calValue = passRaw ? baseValue : adjusted;
endmodule : calibration_adjust

// ==== phy_load_responder.sv ====
/* PHY-side responder for the control loader handshake.
   Assumes the request stays up until it is acknowledged. */
`timescale 1ns/10ps
module phy_load_responder #(
  parameter int DELAY = 12
) (
  // Clock
  input  wire logic clk,
  // Load handshake
  input  wire logic phyLoadReq,
  output logic      phyLoadAck
);
  int cnt = 0;
  initial phyLoadAck = 1'b0;
  always @(posedge clk) begin
    cnt <= (phyLoadReq && !phyLoadAck) ? cnt + 1 : 0;
    phyLoadAck <= phyLoadReq && !phyLoadAck && (cnt == DELAY);
  end
endmodule : phy_load_responder

// ==== usb2_host_port_phy_control_tb.sv ====
/* Register-level bench for the port and PHY control block.
   Assumes a one-clock design; the responder answers loads slowly. */
`timescale 1ns/10ps
module usb2_host_port_phy_control_tb;
  logic        clk = 0, rstn = 0, avsRead = 0, avsWrite = 0, configure_flag_register = 0;
  logic        ev = 0, indCap = 0, running = 0, lbDone = 0, crcGood = 0;
  logic [7:0]  avsAddress = 8'h00;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rdata;
  logic [9:0]  companionOwned, wakeEvent;
  logic [11:0] rxFifoBytes = 12'h000;
  logic [6:0]  phyCalValue;
  logic        avsWaitRequest, rxBusStart, phyLoadReq, phyLoadAck, memOff, busOff;
  logic        ldGrp, ldFull, txStart;
  logic [3:0]  ldTgt;
  logic [6:0]  ldVal;
  logic [19:0] indState;
  logic [39:0] phy_test_select;
  int          badCount = 0, nTests = 0;
  initial forever #5 clk = ~clk;
  usb2_host_port_phy_control DUT (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .configure_flag_register(configure_flag_register), .indicatorCapable(indCap), .controllerRunning(running),
    .connectIrq(ev), .connectEvent({10{ev}}), .disconnectEvent({10{ev}}),
    .overCurrentEvent({10{ev}}), .wakeEvent(wakeEvent), .companionOwned(companionOwned),
    .indicatorState(indState), .phy_test_select(phy_test_select), .portPhyState({10{8'hA5}}),
    .rxFifoBytes(rxFifoBytes), .txFifoBytes(rxFifoBytes), .rxBusStart(rxBusStart),
    .txUtmiStart(txStart), .phyLoadReq(phyLoadReq),
    .phyLoadTarget(ldTgt), .phyLoadValue(ldVal), .phyLoadGroup(ldGrp), .phyLoadFull(ldFull),
    .phyLoadAck(phyLoadAck), .loopbackEnable(), .loopbackDone(lbDone),
    .loopbackCrcGood(crcGood), .memClockOff(memOff), .busClockOff(busOff),
    .phyCalValue(phyCalValue));
  phy_load_responder PHY (.clk(clk), .phyLoadReq(phyLoadReq), .phyLoadAck(phyLoadAck));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
      i++;
    end while (avsWaitRequest !== 1'b0 && i < 50);
    rdata = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (i >= 50) begin
      badCount++;
      stop_test;
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h44, 32'h00002000);
    rd(8'h84, 32'h00600010);
    rd(8'h94, 32'h00001000);
    configure_flag_register <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h44, 32'h0);
    bus(1'b1, 8'h44, 32'h0074E000);
    rd(8'h44, 32'h00742000);
    chk(companionOwned[0], 1'b1);
    indCap <= 1'b1;
    bus(1'b1, 8'h44, 32'h0074A000);
    @(posedge clk);
    chk(indState[1:0], 2'h2);
    chk(phy_test_select[3:0], 4'h4);
    ev <= 1'b1;
    repeat (2) @(posedge clk);
    chk(wakeEvent[0], 1'b1);
    ev <= 1'b0;
    $display("port fields done");
    bus(1'b1, 8'h84, 32'h00600008);
    rxFifoBytes <= 12'h03F;
    repeat (3) @(posedge clk);
    chk(rxBusStart, 1'b0);
    rxFifoBytes <= 12'h040;
    repeat (3) @(posedge clk);
    chk(rxBusStart, 1'b1);
    chk(txStart, 1'b0);
    rxFifoBytes <= 12'h300;
    repeat (3) @(posedge clk);
    chk(txStart, 1'b1);
    rd(8'h88, 32'h25252525);
    rd(8'h90, 32'h25250000);
    bus(1'b1, 8'h94, 32'h00004055);
    @(posedge clk);
    chk({phyLoadReq, ldFull, ldGrp, ldTgt, ldVal}, {1'b1, 1'b1, 1'b0, 4'h2, 7'h55});
    bus(1'b1, 8'h94, 32'h00001055);
    rd(8'h94, 32'h00024055);
    repeat (20) @(posedge clk);
    rd(8'h94, 32'h00004055);
    bus(1'b1, 8'h94, 32'h0001F0FF);
    @(posedge clk);
    chk({phyLoadReq, ldFull, ldGrp, ldTgt, ldVal}, {1'b1, 1'b0, 1'b1, 4'hF, 7'h0F});
    repeat (20) @(posedge clk);
    bus(1'b1, 8'h94, 32'h00014000);
    repeat (2) @(posedge clk);
    chk(phyLoadReq, 1'b0);
    $display("loader done");
    bus(1'b1, 8'h98, 32'h00000100);
    lbDone <= 1'b1;
    crcGood <= 1'b1;
    @(posedge clk);
    lbDone <= 1'b0;
    rd(8'h98, 32'h00000700);
    crcGood <= 1'b0;
    lbDone <= 1'b1;
    @(posedge clk);
    lbDone <= 1'b0;
    rd(8'h98, 32'h00000500);
    bus(1'b1, 8'h9C, 32'h00001000);
    repeat (2) @(posedge clk);
    chk({memOff, busOff}, 2'h3);
    ev <= 1'b1;
    repeat (2) @(posedge clk);
    chk({memOff, busOff}, 2'h2);
    running <= 1'b1;
    repeat (2) @(posedge clk);
    chk({memOff, busOff}, 2'h0);
    ev <= 1'b0;
    bus(1'b1, 8'hA0, 32'h0002FF00);
    repeat (2) @(posedge clk);
    chk(phyCalValue, 7'h00);
    bus(1'b1, 8'hA0, 32'h0002017F);
    repeat (2) @(posedge clk);
    chk(phyCalValue, 7'h7F);
    bus(1'b1, 8'hA0, 32'h00010005);
    repeat (2) @(posedge clk);
    chk(phyCalValue, 7'h05);
    bus(1'b1, 8'hA0, 32'h00008511);
    repeat (2) @(posedge clk);
    chk(phyCalValue, 7'h05);
    rd(8'h00, 32'h0);
    $display("misc done");
    stop_test;
  end
endmodule : usb2_host_port_phy_control_tb
